// ### verilog/ivob_pkg.sv
// shared constants and types for the interrupt vector offset bank
package ivob_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;

  // ----------------------------------------------------------------
  // flag status and mask registers with their alias addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] FLAG_BASE   = 12'h000;
  localparam logic [11:0] FLAG_CLR    = 12'h004;
  localparam logic [11:0] FLAG_SET    = 12'h008;
  localparam logic [11:0] FLAG_INV    = 12'h00C;
  localparam logic [11:0] MASK_BASE   = 12'h010;
  localparam logic [11:0] MASK_CLR    = 12'h014;
  localparam logic [11:0] MASK_SET    = 12'h018;
  localparam logic [11:0] MASK_INV    = 12'h01C;
  localparam logic [31:0] FLAG_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // per-vector offset registers
  // ----------------------------------------------------------------
  localparam int          NUM_VECTOR_ADDRESS_OFFSET    = 14;
  localparam int          VECTOR_ADDRESS_OFFSET_LSB    = 1;
  localparam int          VECTOR_ADDRESS_OFFSET_W      = 17;
  localparam logic [16:0] VECTOR_ADDRESS_OFFSET_RESET  = 17'h0_0000;
  localparam logic [31:0] VECTOR_ADDRESS_OFFSET_MASK   = 32'h0003_FFFE;
  // index 0 is vector 154 up to index 13 for vector 168; vector 163 has no register
  localparam logic [NUM_VECTOR_ADDRESS_OFFSET-1:0][11:0] VECTOR_ADDRESS_OFFSET_ADDR = {
    12'h7E0, 12'h7DC, 12'h7D8, 12'h7D4, 12'h7D0, 12'h7C8, 12'h7C4,
    12'h7C0, 12'h7BC, 12'h7B8, 12'h7B4, 12'h7B0, 12'h7AC, 12'h7A8};

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_VECTOR_ADDRESS_OFFSET-1:0][VECTOR_ADDRESS_OFFSET_W-1:0] vector_address_offset;
    logic [DATA_W-1:0]               rdata;
  } ivob_top_state_t;

endpackage

// ### verilog/ivob_wr_if.sv
// write request carrier from the decoder to one alias-capable register
`timescale 1ns/1ps
interface ivob_wr_if;
  logic        wr;
  logic        clr;
  logic        set;
  logic        toggle_alias_register;
  logic [31:0] wdata;

  modport drive (output wr, output clr, output set, output toggle_alias_register, output wdata);
  modport sink  (input wr, input clr, input set, input toggle_alias_register, input wdata);
endinterface // ivob_wr_if

// ### verilog/ivob_alias_reg.sv
// one register with plain, clear, set and toggle write paths plus hardware set
`timescale 1ns/1ps
module ivob_alias_reg #(
  parameter int          WIDTH = 32,
  parameter logic [31:0] RESET = 32'h0000_0000
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // decoded software writes
  ivob_wr_if.sink               bus,
  // hardware events and value
  input  wire logic [WIDTH-1:0] hw_set,
  output logic      [WIDTH-1:0] value
);

  typedef struct packed {
    logic [WIDTH-1:0] q;
  } ivob_alias_state_t;

  ivob_alias_state_t st_r;
  ivob_alias_state_t st_nxt;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  // hardware set is applied last so an event never loses to a clear
  always_comb begin
    st_nxt = st_r;
    if (bus.wr) begin
      st_nxt.q = bus.wdata[WIDTH-1:0];
    end
    if (bus.clr) begin
      st_nxt.q = st_r.q & ~bus.wdata[WIDTH-1:0];
    end
    if (bus.set) begin
      st_nxt.q = st_r.q | bus.wdata[WIDTH-1:0];
    end
    if (bus.toggle_alias_register) begin
      st_nxt.q = st_r.q ^ bus.wdata[WIDTH-1:0];
    end
    st_nxt.q = st_nxt.q | hw_set;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r.q <= RESET[WIDTH-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_event_sets_bit: assert property ((|hw_set) |=> ((value & $past(hw_set)) == $past(hw_set)))
    else $error("hardware event did not set its bit");
  a_flag_holds: assert property ((!bus.wr && !bus.clr && !bus.toggle_alias_register) |=> (value & $past(value)) == $past(value))
    else $error("bit dropped without a software write");
  a_clear_alias: assert property ((bus.clr && hw_set == '0) |=> ((value & $past(bus.wdata[WIDTH-1:0])) == '0))
    else $error("clear alias left a bit set");
  a_toggle_alias: assert property (bus.toggle_alias_register |=> value == (($past(value) ^ $past(bus.wdata[WIDTH-1:0])) | $past(hw_set)))
    else $error("toggle alias gave wrong value");

endmodule // ivob_alias_reg

// ### verilog/ivob_top.sv
// interrupt vector offset bank with event flag status and mask registers
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module ivob_top (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // register port
  input  wire logic [11:0]              addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [31:0]              rdata,
  // peripheral events
  input  wire logic [31:0]              periph_en,
  input  wire logic [31:0]              event_in,
  // to the vector generator
  output logic [ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET-1:0][ivob_pkg::VECTOR_ADDRESS_OFFSET_W-1:0] vec_offset,
  output logic                          irq
);

  ivob_pkg::ivob_top_state_t st_r;
  ivob_pkg::ivob_top_state_t st_nxt;

  logic [31:0] flags;
  logic [31:0] mask;
  logic [31:0] hw_set;
  logic        vector_address_offset_hit;

  ivob_wr_if flag_bus ();
  ivob_wr_if mask_bus ();

  // ----------------------------------------------------------------
  // write decode for alias-capable registers
  // ----------------------------------------------------------------
  // plain write at base stores; aliases only touch bits written as one
  assign flag_bus.wr    = wr_en && (addr == ivob_pkg::FLAG_BASE);
  assign flag_bus.clr   = wr_en && (addr == ivob_pkg::FLAG_CLR);
  assign flag_bus.set   = wr_en && (addr == ivob_pkg::FLAG_SET);
  assign flag_bus.toggle_alias_register   = wr_en && (addr == ivob_pkg::FLAG_INV);
  assign flag_bus.wdata = wdata;
  assign mask_bus.wr    = wr_en && (addr == ivob_pkg::MASK_BASE);
  assign mask_bus.clr   = wr_en && (addr == ivob_pkg::MASK_CLR);
  assign mask_bus.set   = wr_en && (addr == ivob_pkg::MASK_SET);
  assign mask_bus.toggle_alias_register   = wr_en && (addr == ivob_pkg::MASK_INV);
  assign mask_bus.wdata = wdata;

  // event qualified only by the peripheral enable, never by the mask
  assign hw_set = event_in & periph_en;

  // ----------------------------------------------------------------
  // flag status and mask registers
  // ----------------------------------------------------------------
  ivob_alias_reg #(
    .WIDTH (32),
    .RESET (ivob_pkg::FLAG_RESET)
  ) u_flags (
    .mclk   (mclk),
    .reset  (reset),
    .bus    (flag_bus),
    .hw_set (hw_set),
    .value  (flags)
  );

  ivob_alias_reg #(
    .WIDTH (32),
    .RESET (ivob_pkg::MASK_RESET)
  ) u_mask (
    .mclk   (mclk),
    .reset  (reset),
    .bus    (mask_bus),
    .hw_set (32'h0000_0000),
    .value  (mask)
  );

  // level interrupt while any unmasked flag is set
  assign irq = |(flags & mask);

  // ----------------------------------------------------------------
  // offset register hit detect
  // ----------------------------------------------------------------
  always_comb begin
    vector_address_offset_hit = 1'b0;
    for (int i = 0; i < ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET; i++) begin
      if (addr == ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[i]) begin
        vector_address_offset_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // offset registers and read data
  // ----------------------------------------------------------------
  // exact address match only, so alias addresses land on a neighbour or nowhere
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 32'h0000_0000;
    for (int i = 0; i < ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET; i++) begin
      if (wr_en && (addr == ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[i])) begin
        st_nxt.vector_address_offset[i] = wdata[ivob_pkg::VECTOR_ADDRESS_OFFSET_LSB +: ivob_pkg::VECTOR_ADDRESS_OFFSET_W];
      end
    end
    if (rd_en) begin
      if (addr == ivob_pkg::FLAG_BASE) begin
        st_nxt.rdata = flags;
      end else if (addr == ivob_pkg::MASK_BASE) begin
        st_nxt.rdata = mask;
      end
      for (int i = 0; i < ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET; i++) begin
        if (addr == ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[i]) begin
          st_nxt.rdata = {14'h0000, st_r.vector_address_offset[i], 1'b0};
        end
      end
    end
  end

  // state register; read data lasts only one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r.vector_address_offset  <= {ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET{ivob_pkg::VECTOR_ADDRESS_OFFSET_RESET}};
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata      = st_r.rdata;
  assign vec_offset = st_r.vector_address_offset;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_voff0_write;
    wr_en && (addr == ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[0]);
  endsequence

  sequence s_voff0_read;
    rd_en && (addr == ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[0]);
  endsequence

  a_vector_address_offset_roundtrip: assert property (s_voff0_write ##1 s_voff0_read |=>
      rdata == ($past(wdata, 2) & ivob_pkg::VECTOR_ADDRESS_OFFSET_MASK))
    else $error("offset readback differs from written value");
  a_vector_address_offset_no_alias: assert property ((wr_en && !vector_address_offset_hit) |=> st_r.vector_address_offset == $past(st_r.vector_address_offset))
    else $error("offset changed on a write elsewhere");
  a_reserved_zero: assert property ((rd_en && vector_address_offset_hit) |=> (rdata & ~ivob_pkg::VECTOR_ADDRESS_OFFSET_MASK) == 32'h0000_0000)
    else $error("unimplemented offset bits read nonzero");
  a_unmapped_zero: assert property ((rd_en && !vector_address_offset_hit && addr != ivob_pkg::FLAG_BASE &&
      addr != ivob_pkg::MASK_BASE) |=> rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_poll_masked: assert property ((hw_set != 32'h0000_0000 && mask == 32'h0000_0000 && !mask_bus.wr &&
      !mask_bus.set && !mask_bus.toggle_alias_register) |=> (((flags & $past(hw_set)) == $past(hw_set)) && !irq))
    else $error("masked event not visible as flag or raised irq");
  a_reset_zero: assert property ($fell(reset) |-> st_r.vector_address_offset == '0)
    else $error("offset registers not zero after reset");

endmodule // ivob_top

// ### bench/ivob_top_test.sv
// self-checking bench for the interrupt vector offset bank
`timescale 1ns/1ps
module ivob_top_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk         = 1'b0;
  logic        reset        = 1'b1;
  logic [11:0] addr         = 12'h000;
  logic [31:0] wdata        = 32'h0000_0000;
  logic        wr_en        = 1'b0;
  logic        rd_en        = 1'b0;
  logic [31:0] rdata;
  logic [31:0] periph_en    = 32'h0000_0000;
  logic [31:0] event_in     = 32'h0000_0000;
  logic [ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET-1:0][ivob_pkg::VECTOR_ADDRESS_OFFSET_W-1:0] vec_offset;
  logic        irq;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  logic [31:0] d;

  ivob_top DUT (
    .mclk       (mclk),
    .reset      (reset),
    .addr       (addr),
    .wdata      (wdata),
    .wr_en      (wr_en),
    .rd_en      (rd_en),
    .rdata      (rdata),
    .periph_en  (periph_en),
    .event_in   (event_in),
    .vec_offset (vec_offset),
    .irq        (irq)
  );

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict in one place, shared by the main sequence and the timeout
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe; the next call always leaves a gap cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // read data only stand in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // one-cycle event with the enables held as a level afterwards
  task automatic pulse(input logic [31:0] en, input logic [31:0] ev);
    @(posedge mclk);
    periph_en <= en;
    event_in  <= ev;
    @(posedge mclk);
    event_in  <= 32'h0000_0000;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    // reset values
    rd_chk(ivob_pkg::FLAG_BASE, ivob_pkg::FLAG_RESET);
    rd_chk(ivob_pkg::MASK_BASE, ivob_pkg::MASK_RESET);
    for (int i = 0; i < ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET; i++) begin
      rd_chk(ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[i], 32'h0000_0000);
    end
    check({31'h0, irq}, 32'h0000_0000);
    // distinct values per register catch decode overlaps; spare bits set
    for (int i = 0; i < ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET; i++) begin
      wr(ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[i], 32'hFFFC_0001 | (32'(i + 1) << 5));
    end
    // no alias slots after offset registers, and the vector 163 hole
    wr(12'h7E4, 32'hFFFF_FFFF);
    wr(12'h7E8, 32'hFFFF_FFFF);
    wr(12'h7CC, 32'hFFFF_FFFF);
    for (int i = 0; i < ivob_pkg::NUM_VECTOR_ADDRESS_OFFSET; i++) begin
      d = (32'hFFFC_0001 | (32'(i + 1) << 5)) & ivob_pkg::VECTOR_ADDRESS_OFFSET_MASK;
      rd_chk(ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[i], d);
      check({15'h0, vec_offset[i]}, {15'h0, d[17:1]});
    end
    rd_chk(12'h7CC, 32'h0000_0000);
    // write then read with no gap, so the readback is taken straight after the write
    @(posedge mclk);
    addr  <= ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[0];
    wdata <= 32'hFFFD_2347;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 check(rdata, 32'hFFFD_2347 & ivob_pkg::VECTOR_ADDRESS_OFFSET_MASK);
    // flag raised only with its enable, and with the mask all zero
    pulse(32'h0000_0008, 32'h0000_0009);
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_0008);
    check({31'h0, irq}, 32'h0000_0000);
    repeat (8) @(posedge mclk);
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_0008);
    // set, clear and toggle aliases of the flag register
    wr(ivob_pkg::FLAG_SET, 32'h0000_00F0);
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_00F8);
    wr(ivob_pkg::FLAG_CLR, 32'h0000_0008);
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_00F0);
    wr(ivob_pkg::FLAG_INV, 32'h0000_0011);
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_00E1);
    rd_chk(ivob_pkg::FLAG_SET, 32'h0000_0000);
    // mask aliases in turn, a gap cycle apart: ((3 | 4) & ~1) ^ F = 9
    wr(ivob_pkg::MASK_BASE, 32'h0000_0003);
    wr(ivob_pkg::MASK_SET, 32'h0000_0004);
    wr(ivob_pkg::MASK_CLR, 32'h0000_0001);
    wr(ivob_pkg::MASK_INV, 32'h0000_000F);
    rd_chk(ivob_pkg::MASK_BASE, 32'h0000_0009);
    check({31'h0, irq}, 32'h0000_0001);
    wr(ivob_pkg::FLAG_CLR, 32'hFFFF_FFFF);
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    // event and clear in the same cycle: the event must not be lost
    @(posedge mclk);
    periph_en <= 32'h0000_0001;
    event_in  <= 32'h0000_0001;
    addr      <= ivob_pkg::FLAG_CLR;
    wdata     <= 32'h0000_0001;
    wr_en     <= 1'b1;
    @(posedge mclk);
    event_in  <= 32'h0000_0000;
    wr_en     <= 1'b0;
    rd_chk(ivob_pkg::FLAG_BASE, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    // second reset mid-run clears offsets, flags and the interrupt
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(ivob_pkg::VECTOR_ADDRESS_OFFSET_ADDR[1], 32'h0000_0000);
    rd_chk(ivob_pkg::FLAG_BASE, ivob_pkg::FLAG_RESET);
    check({31'h0, irq}, 32'h0000_0000);
    complete_run();
  end
endmodule // ivob_top_test
